// *** hw/lsm_top.sv ***
`timescale 1ns/1ps
module lsm_top (
	input  wire logic       CLK_IN,
	input  wire logic       RESET_IN,
	input  wire logic [6:0] ADDR_IN,
	input  wire logic       WR_STROBE_IN,
	input  wire logic [7:0] WR_DATA_IN,
	input  wire logic       RD_STROBE_IN,
	output logic      [7:0] RD_DATA_OUT,
	output logic            RD_VALID_OUT,
	output logic            WR_IGNORED_OUT,
	input  wire logic [5:0] LIMIT_ONE_IN,
	input  wire logic       FAN_ONE_AUX_MODE_IN,
	input  wire logic       FAN_ONE_COUNT_IN,
	input  wire logic       AUX_ONE_LIMIT_IN,
	input  wire logic       FAN_TWO_AUX_MODE_IN,
	input  wire logic       FAN_TWO_COUNT_IN,
	input  wire logic       AUX_TWO_LIMIT_IN,
	input  wire logic [1:0] LIMIT_TWO_IN,
	input  wire logic       CHASSIS_INTRUSION_INPUT_IN,
	input  wire logic       OVERTEMP_SIGNAL_N_IN,
	input  wire logic       REMOTE_DIODE_ONE_FAULT_IN,
	input  wire logic       REMOTE_DIODE_TWO_FAULT_IN,
	input  wire logic [7:0] PRIMARY_CLEAR_ONE_IN,
	input  wire logic [7:0] PRIMARY_CLEAR_TWO_IN,
	input  wire logic       EXTERNAL_IRQ_ENABLE_IN,
	input  wire logic       ID_BIT3_IRQ_INPUT_IN,
	input  wire logic       ID_BIT4_IRQ_INPUT_IN,
	output logic            IRQ3_REQUEST_OUT,
	output logic            IRQ4_REQUEST_OUT,
	output logic            OVERTEMP_ACPI_MODE_OUT,
	output logic            ONCE_MODE_OUT,
	output logic            ALERT_MODE_ENABLE_OUT,
	output logic            REINIT_OUT,
	output logic      [7:0] STATUS_ONE_OUT,
	output logic      [7:0] STATUS_TWO_OUT
);

	typedef struct packed {
		logic [7:0] rd_data;
		logic       rd_valid;
		logic       wr_ignored;
		logic [7:0] irq_mode;
		logic [7:0] alert_mode;
		logic       reinit;
		logic       irq3;
		logic       irq4;
	} lsm_top_state_t;

	lsm_top_state_t st_q;
	lsm_top_state_t st_d;

	logic [7:0]        event_one;
	logic [7:0]        event_two;
	logic [7:0]        flags_one;
	logic [7:0]        flags_two;
	logic              reinit_now;
	lsm_pkg::lsm_sel_t wr_sel;
	lsm_pkg::lsm_sel_t rd_sel;

	// address decode shared by reads and writes
	function automatic lsm_pkg::lsm_sel_t decode_addr(
		input logic [6:0] addr
	);
		lsm_pkg::lsm_sel_t sel;
		if (addr == lsm_pkg::LSM_ADDR_CONFIG) begin
			sel = lsm_pkg::LSM_SEL_CONFIG;
		end else if (addr == lsm_pkg::LSM_ADDR_IRQ_MODE) begin
			sel = lsm_pkg::LSM_SEL_IRQ_MODE;
		end else if (addr == lsm_pkg::LSM_ADDR_COPY_ONE) begin
			sel = lsm_pkg::LSM_SEL_COPY_ONE;
		end else if (addr == lsm_pkg::LSM_ADDR_COPY_TWO) begin
			sel = lsm_pkg::LSM_SEL_COPY_TWO;
		end else if (addr == lsm_pkg::LSM_ADDR_ALERT_MODE) begin
			sel = lsm_pkg::LSM_SEL_ALERT_MODE;
		end else begin
			sel = lsm_pkg::LSM_SEL_NONE;
		end
		return sel;
	endfunction

	assign wr_sel = decode_addr(ADDR_IN);
	assign rd_sel = decode_addr(ADDR_IN);

	// reinitialise request from the configuration register
	assign reinit_now = WR_STROBE_IN &&
		(wr_sel == lsm_pkg::LSM_SEL_CONFIG) &&
		WR_DATA_IN[lsm_pkg::LSM_CFG_REINIT_BIT];

	lsm_event_map u_event_map (
		.clk_in              (CLK_IN),
		.reset_in            (RESET_IN),
		.limit_one_in        (LIMIT_ONE_IN),
		.fan_one_aux_mode_in (FAN_ONE_AUX_MODE_IN),
		.fan_one_count_in    (FAN_ONE_COUNT_IN),
		.aux_one_limit_in    (AUX_ONE_LIMIT_IN),
		.fan_two_aux_mode_in (FAN_TWO_AUX_MODE_IN),
		.fan_two_count_in    (FAN_TWO_COUNT_IN),
		.aux_two_limit_in    (AUX_TWO_LIMIT_IN),
		.limit_two_in        (LIMIT_TWO_IN),
		.chassis_in          (CHASSIS_INTRUSION_INPUT_IN),
		.overtemp_n_in       (OVERTEMP_SIGNAL_N_IN),
		.diode_one_fault_in  (REMOTE_DIODE_ONE_FAULT_IN),
		.diode_two_fault_in  (REMOTE_DIODE_TWO_FAULT_IN),
		.event_one_out       (event_one),
		.event_two_out       (event_two)
	);

	// first status set, sticky until the primary copy is cleared
	lsm_flag_bank u_flags_one (
		.clk_in    (CLK_IN),
		.reset_in  (RESET_IN),
		.wipe_in   (reinit_now),
		.set_in    (event_one),
		.clear_in  (PRIMARY_CLEAR_ONE_IN),
		.flags_out (flags_one)
	);

	// second status set, reserved lanes never set
	lsm_flag_bank u_flags_two (
		.clk_in    (CLK_IN),
		.reset_in  (RESET_IN),
		.wipe_in   (reinit_now),
		.set_in    (event_two),
		.clear_in  (PRIMARY_CLEAR_TWO_IN & lsm_pkg::LSM_COPY_TWO_VALID),
		.flags_out (flags_two)
	);

	always_comb begin
		st_d            = st_q;
		st_d.rd_valid   = 1'b0;
		st_d.wr_ignored = 1'b0;
		st_d.reinit     = reinit_now;

		// register writes
		if (WR_STROBE_IN) begin
			case (wr_sel)
				lsm_pkg::LSM_SEL_IRQ_MODE: begin
					st_d.irq_mode = (WR_DATA_IN &
						lsm_pkg::LSM_IRQ_MODE_WMASK) |
						(st_q.irq_mode &
						~lsm_pkg::LSM_IRQ_MODE_WMASK);
				end
				lsm_pkg::LSM_SEL_ALERT_MODE: begin
					st_d.alert_mode = (WR_DATA_IN &
						lsm_pkg::LSM_ALERT_MODE_WMASK) |
						(st_q.alert_mode &
						~lsm_pkg::LSM_ALERT_MODE_WMASK);
				end
				lsm_pkg::LSM_SEL_COPY_ONE: begin
					st_d.wr_ignored = 1'b1;
				end
				lsm_pkg::LSM_SEL_COPY_TWO: begin
					st_d.wr_ignored = 1'b1;
				end
				lsm_pkg::LSM_SEL_CONFIG: begin
					st_d.wr_ignored = 1'b0;
				end
				default: begin
					st_d.wr_ignored = 1'b1;
				end
			endcase
		end

		// reinitialise returns control state to reset values
		if (reinit_now) begin
			st_d.irq_mode   = lsm_pkg::LSM_RST_IRQ_MODE;
			st_d.alert_mode = lsm_pkg::LSM_RST_ALERT_MODE;
		end

		// register reads, no side effects on the flags
		if (RD_STROBE_IN) begin
			st_d.rd_valid = 1'b1;
			case (rd_sel)
				lsm_pkg::LSM_SEL_COPY_ONE: begin
					st_d.rd_data = flags_one &
						lsm_pkg::LSM_COPY_ONE_VALID;
				end
				lsm_pkg::LSM_SEL_COPY_TWO: begin
					st_d.rd_data = flags_two &
						lsm_pkg::LSM_COPY_TWO_VALID;
				end
				lsm_pkg::LSM_SEL_IRQ_MODE: begin
					st_d.rd_data = st_q.irq_mode;
				end
				lsm_pkg::LSM_SEL_ALERT_MODE: begin
					st_d.rd_data = st_q.alert_mode;
				end
				default: begin
					st_d.rd_data = lsm_pkg::LSM_RD_UNMAPPED;
				end
			endcase
		end

		// external interrupt inputs
		st_d.irq3 = st_q.irq_mode[lsm_pkg::LSM_IRQ3_EN_BIT] &
			EXTERNAL_IRQ_ENABLE_IN & ID_BIT3_IRQ_INPUT_IN;
		st_d.irq4 = st_q.irq_mode[lsm_pkg::LSM_IRQ4_EN_BIT] &
			EXTERNAL_IRQ_ENABLE_IN & ID_BIT4_IRQ_INPUT_IN;
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign RD_DATA_OUT            = st_q.rd_data;
	assign RD_VALID_OUT           = st_q.rd_valid;
	assign WR_IGNORED_OUT         = st_q.wr_ignored;
	assign REINIT_OUT             = st_q.reinit;
	assign IRQ3_REQUEST_OUT       = st_q.irq3;
	assign IRQ4_REQUEST_OUT       = st_q.irq4;
	assign OVERTEMP_ACPI_MODE_OUT =
		st_q.irq_mode[lsm_pkg::LSM_OVERTEMP_SIGNAL_MODE_BIT];
	assign ONCE_MODE_OUT          = st_q.irq_mode[lsm_pkg::LSM_ONCE_BIT];
	assign ALERT_MODE_ENABLE_OUT  =
		st_q.alert_mode[lsm_pkg::LSM_ALERT_EN_BIT];
	assign STATUS_ONE_OUT         = flags_one;
	assign STATUS_TWO_OUT         = flags_two;

endmodule

// *** hw/lsm_pkg.sv ***
package lsm_pkg;

	// register addresses on the seven-bit management register port
	localparam logic [6:0] LSM_ADDR_CONFIG     = 7'h40;
	localparam logic [6:0] LSM_ADDR_IRQ_MODE   = 7'h4a;
	localparam logic [6:0] LSM_ADDR_COPY_ONE   = 7'h4c;
	localparam logic [6:0] LSM_ADDR_COPY_TWO   = 7'h4d;
	localparam logic [6:0] LSM_ADDR_ALERT_MODE = 7'h4e;

	// reset values and the value read at unmapped addresses
	localparam logic [7:0] LSM_RST_COPY_ONE    = 8'h00;
	localparam logic [7:0] LSM_RST_COPY_TWO    = 8'h00;
	localparam logic [7:0] LSM_RST_IRQ_MODE    = 8'h00;
	localparam logic [7:0] LSM_RST_ALERT_MODE  = 8'h00;
	localparam logic [7:0] LSM_RD_UNMAPPED     = 8'h00;

	// field positions
	localparam int LSM_CFG_REINIT_BIT   = 7;
	localparam int LSM_ONCE_BIT         = 3;
	localparam int LSM_OVERTEMP_SIGNAL_MODE_BIT   = 4;
	localparam int LSM_IRQ3_EN_BIT      = 6;
	localparam int LSM_IRQ4_EN_BIT      = 7;
	localparam int LSM_ALERT_EN_BIT     = 6;
	localparam int LSM_ONE_FAN1_BIT     = 6;
	localparam int LSM_ONE_FAN2_BIT     = 7;
	localparam int LSM_TWO_CHASSIS_BIT  = 4;
	localparam int LSM_TWO_OVERTEMP_BIT = 5;
	localparam int LSM_TWO_DIODE1_BIT   = 6;
	localparam int LSM_TWO_DIODE2_BIT   = 7;

	// writable bits and implemented flag bits
	localparam logic [7:0] LSM_IRQ_MODE_WMASK   = 8'hd8;
	localparam logic [7:0] LSM_ALERT_MODE_WMASK = 8'h40;
	localparam logic [7:0] LSM_COPY_ONE_VALID   = 8'hff;
	localparam logic [7:0] LSM_COPY_TWO_VALID   = 8'hf3;

	typedef enum {
		LSM_SEL_NONE,
		LSM_SEL_CONFIG,
		LSM_SEL_IRQ_MODE,
		LSM_SEL_COPY_ONE,
		LSM_SEL_COPY_TWO,
		LSM_SEL_ALERT_MODE
	} lsm_sel_t;

endpackage

// *** hw/lsm_event_map.sv ***
`timescale 1ns/1ps
module lsm_event_map (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [5:0] limit_one_in,
	input  wire logic       fan_one_aux_mode_in,
	input  wire logic       fan_one_count_in,
	input  wire logic       aux_one_limit_in,
	input  wire logic       fan_two_aux_mode_in,
	input  wire logic       fan_two_count_in,
	input  wire logic       aux_two_limit_in,
	input  wire logic [1:0] limit_two_in,
	input  wire logic       chassis_in,
	input  wire logic       overtemp_n_in,
	input  wire logic       diode_one_fault_in,
	input  wire logic       diode_two_fault_in,
	output logic      [7:0] event_one_out,
	output logic      [7:0] event_two_out
);

	typedef struct packed {
		logic [7:0] ev_one;
		logic [7:0] ev_two;
	} lsm_map_state_t;

	lsm_map_state_t st_q;
	lsm_map_state_t st_d;

	always_comb begin
		st_d        = st_q;
		st_d.ev_one = 8'h00;
		st_d.ev_two = 8'h00;
		st_d.ev_one[5:0] = limit_one_in;
		st_d.ev_one[lsm_pkg::LSM_ONE_FAN1_BIT] = fan_one_aux_mode_in ?
			aux_one_limit_in : fan_one_count_in;
		st_d.ev_one[lsm_pkg::LSM_ONE_FAN2_BIT] = fan_two_aux_mode_in ?
			aux_two_limit_in : fan_two_count_in;
		st_d.ev_two[1:0] = limit_two_in;
		st_d.ev_two[lsm_pkg::LSM_TWO_CHASSIS_BIT]  = chassis_in;
		st_d.ev_two[lsm_pkg::LSM_TWO_OVERTEMP_BIT] = ~overtemp_n_in;
		st_d.ev_two[lsm_pkg::LSM_TWO_DIODE1_BIT]   = diode_one_fault_in;
		st_d.ev_two[lsm_pkg::LSM_TWO_DIODE2_BIT]   = diode_two_fault_in;
		st_d.ev_one = st_d.ev_one & lsm_pkg::LSM_COPY_ONE_VALID;
		st_d.ev_two = st_d.ev_two & lsm_pkg::LSM_COPY_TWO_VALID;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign event_one_out = st_q.ev_one;
	assign event_two_out = st_q.ev_two;

endmodule

// *** hw/lsm_flag_bank.sv ***
`timescale 1ns/1ps
module lsm_flag_bank (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       wipe_in,
	input  wire logic [7:0] set_in,
	input  wire logic [7:0] clear_in,
	output logic      [7:0] flags_out
);

	typedef struct packed {
		logic [7:0] flags;
	} lsm_bank_state_t;

	lsm_bank_state_t st_q;
	lsm_bank_state_t st_d;
	logic      [7:0] nxt;

	// per flag: set wins over clear, wipe wins over both
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_flag
			assign nxt[i] = wipe_in ? 1'b0 :
				(set_in[i] | (st_q.flags[i] & ~clear_in[i]));
		end
	endgenerate

	always_comb begin
		st_d       = st_q;
		st_d.flags = nxt;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flags_out = st_q.flags;

endmodule

// *** verif/lsm_checker.sv ***
`timescale 1ns/1ps
module lsm_checker (
	input wire logic       CLK_IN,
	input wire logic       RESET_IN,
	input wire logic [6:0] ADDR_IN,
	input wire logic       WR_STROBE_IN,
	input wire logic [7:0] WR_DATA_IN,
	input wire logic       RD_STROBE_IN,
	input wire logic       RD_VALID_OUT,
	input wire logic       WR_IGNORED_OUT,
	input wire logic       CHASSIS_INTRUSION_INPUT_IN,
	input wire logic       OVERTEMP_SIGNAL_N_IN,
	input wire logic       EXTERNAL_IRQ_ENABLE_IN,
	input wire logic       IRQ3_REQUEST_OUT,
	input wire logic       IRQ4_REQUEST_OUT,
	input wire logic       OVERTEMP_ACPI_MODE_OUT,
	input wire logic       REINIT_OUT,
	input wire logic [7:0] STATUS_ONE_OUT,
	input wire logic [7:0] STATUS_TWO_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	logic re_w;
	assign re_w = WR_STROBE_IN && ADDR_IN == 7'h40 && WR_DATA_IN[7];
	rd_answer_a: assert property (RD_STROBE_IN |=> RD_VALID_OUT)
		else $error("read not answered");
	acpi_mode_a: assert property (WR_STROBE_IN &&
		ADDR_IN == 7'h4a |=>
		OVERTEMP_ACPI_MODE_OUT == $past(WR_DATA_IN[4])) else $error("acpi");
	irq3_gate_a: assert property (!EXTERNAL_IRQ_ENABLE_IN |=>
		!IRQ3_REQUEST_OUT) else $error("irq3 not gated");
	irq4_gate_a: assert property (!EXTERNAL_IRQ_ENABLE_IN |=>
		!IRQ4_REQUEST_OUT) else $error("irq4 not gated");
	reinit_wipe_a: assert property (re_w |=> REINIT_OUT &&
		STATUS_ONE_OUT == 8'h00 && STATUS_TWO_OUT == 8'h00)
		else $error("reinit");
	chassis_flag_a: assert property (CHASSIS_INTRUSION_INPUT_IN &&
		!re_w ##1 !re_w |=> STATUS_TWO_OUT[4]) else $error("chassis");
	overtemp_flag_a: assert property (!OVERTEMP_SIGNAL_N_IN &&
		!re_w ##1 !re_w |=> STATUS_TWO_OUT[5]) else $error("overtemp");
	copy_write_a: assert property (WR_STROBE_IN &&
		ADDR_IN inside {7'h4c, 7'h4d} |=> WR_IGNORED_OUT)
		else $error("copy write");
endmodule

// *** verif/lsm_host_model.sv ***
`timescale 1ns/1ps
module lsm_host_model (
	input  wire logic       clk_in,
	output logic      [6:0] addr_out,
	output logic            wr_out,
	output logic      [7:0] wdata_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	input  wire logic       ignored_in
);
	initial begin
		{addr_out, wr_out, wdata_out, rd_out} = 17'h0;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d,
		output logic ign);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
		ign = ignored_in;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule

// *** verif/limit_status_mirror_test.sv ***
`timescale 1ns/1ps
module limit_status_mirror_test;
	logic       clk, rst, wr, rd, rv, ign, ext, p3, p4, i3, i4;
	logic       acpi, once, alrt, rei, m1, f1, a1, m2, f2, a2;
	logic       ci, ot_n, d1, d2, v, ig;
	logic [6:0] addr;
	logic [7:0] wd, rdat, s1, s2, c1, c2, got, rnd;
	logic [5:0] l1;
	logic [1:0] l2;
	int         error_cnt, comparisons, e1, e2, mode;
	lsm_top dut (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
		.WR_STROBE_IN(wr), .WR_DATA_IN(wd), .RD_STROBE_IN(rd),
		.RD_DATA_OUT(rdat), .RD_VALID_OUT(rv), .WR_IGNORED_OUT(ign),
		.LIMIT_ONE_IN(l1), .FAN_ONE_AUX_MODE_IN(m1), .FAN_ONE_COUNT_IN(f1),
		.AUX_ONE_LIMIT_IN(a1), .FAN_TWO_AUX_MODE_IN(m2),
		.FAN_TWO_COUNT_IN(f2), .AUX_TWO_LIMIT_IN(a2), .LIMIT_TWO_IN(l2),
		.CHASSIS_INTRUSION_INPUT_IN(ci), .OVERTEMP_SIGNAL_N_IN(ot_n),
		.REMOTE_DIODE_ONE_FAULT_IN(d1), .REMOTE_DIODE_TWO_FAULT_IN(d2),
		.PRIMARY_CLEAR_ONE_IN(c1), .PRIMARY_CLEAR_TWO_IN(c2),
		.EXTERNAL_IRQ_ENABLE_IN(ext), .ID_BIT3_IRQ_INPUT_IN(p3),
		.ID_BIT4_IRQ_INPUT_IN(p4), .IRQ3_REQUEST_OUT(i3),
		.IRQ4_REQUEST_OUT(i4), .OVERTEMP_ACPI_MODE_OUT(acpi),
		.ONCE_MODE_OUT(once), .ALERT_MODE_ENABLE_OUT(alrt),
		.REINIT_OUT(rei), .STATUS_ONE_OUT(s1), .STATUS_TWO_OUT(s2));
	lsm_host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr),
		.wdata_out(wd), .rd_out(rd), .rdata_in(rdat), .rvalid_in(rv),
		.ignored_in(ign));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, got, v);
		chk("rd_valid", 8'h01, {7'h00, v});
		chk("rd_data", e, got);
	endtask
	task automatic idle();
		{l1, l2, m1, f1, a1, m2, f2, a2, ci, d1, d2} = 17'h0;
		ot_n = 1'b1;
	endtask
	task automatic ev();
		@(negedge clk);
		{l1, m1, f1, a1, m2, f2, a2} = 12'($urandom);
		{l2, ci, d1, d2, ot_n} = 6'($urandom);
		e1 |= {m2 ? a2 : f2, m1 ? a1 : f1, l1};
		e2 |= {d2, d1, !ot_n, ci, 2'b00, l2};
		@(negedge clk);
		idle();
	endtask
	initial begin
		#40000;
		error_cnt++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h2c86));
		{rst, ext, p3, p4, c1, c2, e1, e2} = {4'h8, 16'h0, 64'h0};
		idle();
		repeat (3) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		rdchk(7'h4c, 8'h00);
		rdchk(7'h4d, 8'h00);
		rdchk(7'h7f, 8'h00);
		repeat (6) begin
			ev();
			rdchk(7'h4c, e1[7:0]);
			rdchk(7'h4d, e2[7:0]);
			rdchk(7'h4c, e1[7:0]);
			chk("status_one", e1[7:0], s1);
			chk("status_two", e2[7:0], s2);
			host.wr(7'h4d, 8'hff, ig);
			chk("ignored", 8'h01, {7'h00, ig});
			rdchk(7'h4d, e2[7:0]);
			host.wr(7'h4c, 8'hff, ig);
			chk("ignored", 8'h01, {7'h00, ig});
			rdchk(7'h4c, e1[7:0]);
			@(negedge clk);
			{c1, c2} = 16'($urandom);
			e1 &= ~c1;
			e2 &= ~c2;
			@(negedge clk);
			{c1, c2} = 16'h0;
			rdchk(7'h4c, e1[7:0]);
			chk("status_two", e2[7:0], s2);
		end
		repeat (4) begin
			rnd = 8'($urandom);
			host.wr(7'h4a, rnd, ig);
			mode = rnd & 8'hd8;
			rdchk(7'h4a, mode[7:0]);
			chk("acpi", {7'h00, mode[4]}, {7'h00, acpi});
			chk("once", {7'h00, mode[3]}, {7'h00, once});
			for (int k = 0; k < 8; k++) begin
				@(negedge clk);
				{ext, p3, p4} = 3'(k);
				@(negedge clk);
				chk("irq3", {7'h00, mode[6] & ext & p3}, {7'h00, i3});
				chk("irq4", {7'h00, mode[7] & ext & p4}, {7'h00, i4});
			end
		end
		host.wr(7'h4e, 8'hff, ig);
		rdchk(7'h4e, 8'h40);
		chk("alert", 8'h01, {7'h00, alrt});
		ev();
		host.wr(7'h40, 8'h7f, ig);
		chk("reinit", 8'h00, {7'h00, rei});
		chk("ignored", 8'h00, {7'h00, ig});
		rdchk(7'h4e, 8'h40);
		host.wr(7'h40, 8'h80, ig);
		chk("reinit", 8'h01, {7'h00, rei});
		rdchk(7'h4c, 8'h00);
		rdchk(7'h4d, 8'h00);
		rdchk(7'h4a, 8'h00);
		rdchk(7'h4e, 8'h00);
		chk("once", 8'h00, {7'h00, once});
		chk("acpi", 8'h00, {7'h00, acpi});
		stop_test();
	end
endmodule
bind lsm_top lsm_checker chk (.CLK_IN, .RESET_IN, .ADDR_IN, .WR_STROBE_IN,
	.WR_DATA_IN, .RD_STROBE_IN, .RD_VALID_OUT, .WR_IGNORED_OUT,
	.CHASSIS_INTRUSION_INPUT_IN, .OVERTEMP_SIGNAL_N_IN,
	.EXTERNAL_IRQ_ENABLE_IN, .IRQ3_REQUEST_OUT, .IRQ4_REQUEST_OUT,
	.OVERTEMP_ACPI_MODE_OUT, .REINIT_OUT, .STATUS_ONE_OUT,
	.STATUS_TWO_OUT);
